// File: verilog/pbdp_pkg.sv
// Constants, tables and carrier type for the playback digital path
`default_nettype none
package pbdp_pkg;
    typedef struct packed {
        logic               vld;
        logic signed [23:0] d;
    } pbdp_smp_t;
    typedef enum logic [1:0] {L_HOLD = 2'b00, L_ATK = 2'b01, L_DCY = 2'b10} pbdp_lim_t;
    localparam logic [4:0] IX_PWR  = 5'h03;
    localparam logic [4:0] IX_CTL  = 5'h0A;
    localparam logic [4:0] IX_VOL  = 5'h0B;
    localparam logic [4:0] IX_EQ1  = 5'h12;
    localparam logic [4:0] IX_EQ2  = 5'h13;
    localparam logic [4:0] IX_EQ3  = 5'h14;
    localparam logic [4:0] IX_EQ4  = 5'h15;
    localparam logic [4:0] IX_EQ5  = 5'h16;
    localparam logic [4:0] IX_TIM  = 5'h18;
    localparam logic [4:0] IX_LVL  = 5'h19;
    localparam logic [4:0] IX_STAT = 5'h1F;
    localparam logic [8:0] RST_ZERO = 9'h000;
    localparam logic [8:0] RST_VOL  = 9'h0FF;
    localparam logic [8:0] RST_EQ1  = 9'h12C;
    localparam logic [8:0] RST_EQB  = 9'h02C;
    localparam logic [8:0] RST_TIM  = 9'h032;
    localparam logic [8:0] MSK_PWR  = 9'h0ED;
    localparam logic [8:0] MSK_CTL  = 9'h075;
    localparam logic [8:0] MSK_VOL  = 9'h0FF;
    localparam logic [8:0] MSK_EQ   = 9'h17F;
    localparam logic [8:0] MSK_EQ5  = 9'h07F;
    localparam logic [8:0] MSK_TIM  = 9'h1FF;
    localparam logic [8:0] MSK_LVL  = 9'h07F;
    localparam int B_CONV  = 0;
    localparam int B_POL   = 0;
    localparam int B_ZERO_RUN_MUTE_ENABLE = 2;
    localparam int B_DEEM  = 4;
    localparam int B_SMUTE = 6;
    localparam int B_PATH  = 8;
    localparam int B_WIDE  = 8;
    localparam int B_FREQ  = 5;
    localparam int B_GAIN  = 0;
    localparam int B_ATK   = 0;
    localparam int B_DCY   = 4;
    localparam int B_LIMITER_ENABLE = 8;
    localparam int B_BOOST = 0;
    localparam int B_LVL   = 4;
    localparam logic [9:0] UNITY_EFF = 10'h018;
    localparam logic [8:0] SM_FULL   = 9'h0FF;
    localparam logic [4:0] GAIN_MAX  = 5'h18;
    localparam logic [4:0] GAIN_FLAT = 5'h0C;
    localparam logic [3:0] BOOST_MAX = 4'hC;
    localparam logic [3:0] TCODE_MAX = 4'hB;
    localparam logic [2:0] LVL_MAX   = 3'h5;
    localparam int ATK_T6_US = 94;
    localparam int DCY_T6_US = 750;
    localparam int STEPS_6DB = 12;
    localparam int REF_FS_HZ = 44100;
    localparam int ATK_Q10 = (ATK_T6_US * REF_FS_HZ / 1000) * 1024 / (STEPS_6DB * 1000);
    localparam int DCY_Q10 = (DCY_T6_US * REF_FS_HZ / 1000) * 1024 / (STEPS_6DB * 1000);
    localparam logic [16:0] FRAC [12] = '{17'h10000, 17'h0F1AE, 17'h0E429, 17'h0D766,
        17'h0CB59, 17'h0BFF9, 17'h0B53C, 17'h0AB19, 17'h0A186, 17'h0987D, 17'h08FF6, 17'h087E8};
    localparam logic [15:0] EQ_A [20] = '{16'h02AB, 16'h037F, 16'h047C, 16'h05CC,
        16'h0798, 16'h09DC, 16'h0C95, 16'h1038, 16'h14E1, 16'h1AF5, 16'h2255, 16'h2ADE,
        16'h35C0, 16'h4504, 16'h579C, 16'h6A54, 16'h8016, 16'h983F, 16'hB12F, 16'hC8A8};
    localparam logic [15:0] DE_A [3] = '{16'h76F7, 16'h5D56, 16'h573F};
    localparam logic [15:0] DE_K = 16'h4CCD;
endpackage
`default_nettype wire

// File: verilog/pbdp_top.sv
// Playback digital path: APB registers, volume, EQ, limiter, de-emphasis
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Volume code scales half dB; zero mutes
// - Two-bit de-emphasis select: none, 32/44.1/48k
// - Filters run only while converter enabled
// - Soft mute ramps gain down, then back
// - De-emphasis follows equaliser and volume
// - Polarity bit inverts output phase
// - Mute after 1024 zeros, release instantly
// - Automute enable bit, reset disabled
// - Thresholds half dB around limiter level
// - Above upper threshold, attenuate at attack
// - Below lower threshold, recover at decay
// - Boost zero leaves quiet signals untouched
// - Boost 0 to 12 dB, 1dB steps
// - Boost applies even with limiter off
// - Attack code doubles from 94us per 6dB
// - Decay code doubles from 750us per 6dB
// - Level code -1dB down to -6dB
// - Limiter attenuates only while enabled
// - Path bit puts equaliser in playback
// - Two shelving, three peaking bands, width select
// - Two-bit frequency code per band
// - Band gain code +12dB down to -12dB
module pbdp_top
    import pbdp_pkg::*;
#(
    parameter int LIM_MAX_HDB = 48,
    parameter int ZRUN_LEN    = 1024
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [6:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire pbdp_smp_t   smp_in,
    output pbdp_smp_t        smp_out,
    output logic             zero_run_mute,
    output logic      [8:0]  out_power_en,
    output logic             eq_on_record
);
    localparam logic [6:0]  LMAX = 7'(LIM_MAX_HDB);
    localparam logic [10:0] ZL   = 11'(ZRUN_LEN);

    function automatic logic [17:0] msk_rst(input logic [4:0] i);
        unique case (i)
            IX_PWR:  msk_rst = {MSK_PWR, RST_ZERO};
            IX_CTL:  msk_rst = {MSK_CTL, RST_ZERO};
            IX_VOL:  msk_rst = {MSK_VOL, RST_VOL};
            IX_EQ1:  msk_rst = {MSK_EQ, RST_EQ1};
            IX_EQ2, IX_EQ3, IX_EQ4: msk_rst = {MSK_EQ, RST_EQB};
            IX_EQ5:  msk_rst = {MSK_EQ5, RST_EQB};
            IX_TIM:  msk_rst = {MSK_TIM, RST_TIM};
            IX_LVL:  msk_rst = {MSK_LVL, RST_ZERO};
            default: msk_rst = {RST_ZERO, RST_ZERO};
        endcase
    endfunction

    // Split views of one table entry: reset value and writable bits
    function automatic logic [8:0] rst_of(input logic [4:0] i);
        logic [17:0] t;
        t = msk_rst(i);
        rst_of = t[8:0];
    endfunction

    function automatic logic [8:0] msk_of(input logic [4:0] i);
        logic [17:0] t;
        t = msk_rst(i);
        msk_of = t[17:9];
    endfunction

    // Gain for an attenuation in half dB, offset so that UNITY_EFF is 0dB (Q14)
    function automatic logic [17:0] hdb(input logic [9:0] e);
        logic [5:0] s;
        s = 6'(e / 10'd12);
        hdb = (s > 6'd16) ? 18'h00000 : 18'(FRAC[4'(e % 10'd12)] >> s);
    endfunction

    function automatic logic signed [23:0] sat(input logic signed [55:0] v);
        if (v > 56'sh7FFFFF) sat = 24'sh7FFFFF;
        else if (v < 56'shFFFFFFFF800000) sat = 24'sh800000;
        else sat = v[23:0];
    endfunction

    function automatic logic signed [23:0] mulg(input logic signed [23:0] x,
                                                input logic        [17:0] g);
        logic signed [55:0] p;
        p = 56'(x) * 56'($signed({1'b0, g}));
        mulg = sat(p >>> 14);
    endfunction

    // One-pole low-pass step; state carries 8 fraction bits for low corners
    function automatic logic signed [31:0] onep(input logic signed [31:0] st,
                                                input logic signed [23:0] x,
                                                input logic        [15:0] a);
        logic signed [55:0] p;
        p = ((56'(x) <<< 8) - 56'(st)) * 56'($signed({1'b0, a}));
        onep = st + 32'(p >>> 16);
    endfunction

    logic [8:0] rf_r [32];
    logic [4:0] idx;
    logic       ok;
    logic [8:0] stat;
    assign idx = paddr[6:2];
    assign ok = (paddr[1:0] == 2'b00) && ((msk_rst(idx) != 18'h00000) || (idx == IX_STAT));
    assign pready = 1'b1;
    assign pslverr = psel && penable && !ok;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 32; i++) begin
                rf_r[i] <= rst_of(5'(i));
            end
        end else if (psel && penable && pwrite && ok && idx != IX_STAT) begin
            rf_r[idx] <= pwdata[8:0] & msk_of(idx);
        end
    end

    // Read data is latched in the setup phase so the access phase sees a flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= {23'h000000, (idx == IX_STAT) ? stat : rf_r[idx]};
        end
    end

    logic       conv, pol, amen, smute, path, lim_en;
    logic [1:0] dsel;
    logic [7:0] vol;
    logic [3:0] atkc, dcyc, boost;
    logic [2:0] lc;
    assign conv   = rf_r[IX_PWR][B_CONV];
    assign pol    = rf_r[IX_CTL][B_POL];
    assign amen   = rf_r[IX_CTL][B_ZERO_RUN_MUTE_ENABLE];
    assign dsel   = rf_r[IX_CTL][B_DEEM+:2];
    assign smute  = rf_r[IX_CTL][B_SMUTE];
    assign vol    = rf_r[IX_VOL][7:0];
    assign path   = rf_r[IX_EQ1][B_PATH];
    assign lim_en = rf_r[IX_TIM][B_LIMITER_ENABLE];
    assign atkc   = (rf_r[IX_TIM][B_ATK+:4] > TCODE_MAX) ? TCODE_MAX : rf_r[IX_TIM][B_ATK+:4];
    assign dcyc   = (rf_r[IX_TIM][B_DCY+:4] > TCODE_MAX) ? TCODE_MAX : rf_r[IX_TIM][B_DCY+:4];
    assign boost  = (rf_r[IX_LVL][B_BOOST+:4] > BOOST_MAX) ? BOOST_MAX : rf_r[IX_LVL][B_BOOST+:4];
    assign lc     = (rf_r[IX_LVL][B_LVL+:3] > LVL_MAX) ? LVL_MAX : rf_r[IX_LVL][B_LVL+:3];
    // Mixer and driver enables stay live whatever the converter enable says
    assign out_power_en = rf_r[IX_PWR];
    assign eq_on_record = !path;

    logic v;
    assign v = smp_in.vld && conv;

    // Volume stage with soft-mute ramp added as extra attenuation
    logic [8:0]         sm_r;
    logic signed [23:0] vol_r;
    logic [17:0]        gv;
    assign gv = (vol == 8'h00 || sm_r == SM_FULL) ? 18'h00000 :
                hdb(UNITY_EFF + 10'(8'hFF - vol) + 10'(sm_r));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sm_r <= 9'h000;
        end else if (v && smute && sm_r != SM_FULL) begin
            sm_r <= sm_r + 9'h001;
        end else if (v && !smute && sm_r != 9'h000) begin
            sm_r <= sm_r - 9'h001;
        end
    end

    // Five bands in series within one sample; shelves at the ends
    logic signed [23:0] ew [6];
    logic signed [23:0] eq_r;
    assign ew[0] = vol_r;
    for (genvar b = 0; b < 5; b++) begin : g_band
        logic signed [31:0] s1_r, s2_r, s3_r, n1, n2, n3;
        logic signed [55:0] bnd, p;
        logic [8:0]  f;
        logic [4:0]  gc;
        logic [15:0] a;
        assign f  = rf_r[IX_EQ1 + 5'(b)];
        assign gc = (f[B_GAIN+:5] > GAIN_MAX) ? GAIN_FLAT : f[B_GAIN+:5];
        assign a  = EQ_A[b * 4 + int'(f[B_FREQ+:2])];
        assign n1 = onep(s1_r, ew[b], a);
        assign n2 = onep(s2_r, 24'(n1 >>> 8), a);
        assign n3 = onep(s3_r, 24'(n2 >>> 8), a);
        always_comb begin
            if (b == 0) bnd = 56'(n1);
            else if (b == 4) bnd = (56'(ew[b]) <<< 8) - 56'(n1);
            else if (f[B_WIDE]) bnd = 56'(n1) - 56'(n2);
            else bnd = 56'(n2) - 56'(n3);
            p = bnd * (56'($signed({1'b0, hdb(10'({gc, 1'b0}))})) - 56'sh4000);
        end
        assign ew[b + 1] = sat(56'(ew[b]) + (p >>> 22));
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                s1_r <= 32'h00000000;
                s2_r <= 32'h00000000;
                s3_r <= 32'h00000000;
            end else if (!conv) begin
                s1_r <= 32'h00000000;
                s2_r <= 32'h00000000;
                s3_r <= 32'h00000000;
            end else if (v) begin
                s1_r <= n1;
                s2_r <= n2;
                s3_r <= n3;
            end
        end
    end

    // Limiter with boost; attenuation counted in half dB steps
    pbdp_lim_t          ph_r, ph_nxt;
    logic [6:0]         latt_r;
    logic [12:0]        cnt_r, per;
    logic signed [23:0] lim_r;
    logic [23:0]        mag;
    logic [26:0]        thr_up, thr_lo;
    assign mag    = lim_r[23] ? 24'(-lim_r) : 24'(lim_r);
    assign thr_up = {hdb(UNITY_EFF + 10'({lc, 1'b0}) + 10'd1), 9'h000};
    assign thr_lo = {hdb(UNITY_EFF + 10'({lc, 1'b0}) + 10'd3), 9'h000};

    always_comb begin
        ph_nxt = L_HOLD;
        if (27'(mag) > thr_up) begin
            ph_nxt = L_ATK;
        end else if (latt_r != 7'h00 && (27'(mag) < thr_lo || ph_r == L_DCY)) begin
            ph_nxt = L_DCY;
        end
        unique case (ph_r)
            L_ATK:   per = 13'((ATK_Q10 << atkc) >> 10);
            L_DCY:   per = 13'((DCY_Q10 << dcyc) >> 10);
            default: per = 13'h0001;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_r   <= L_HOLD;
            cnt_r  <= 13'h0000;
            latt_r <= 7'h00;
        end else if (!conv || !lim_en) begin
            ph_r   <= L_HOLD;
            cnt_r  <= 13'h0000;
            latt_r <= 7'h00;
        end else if (v) begin
            ph_r <= ph_nxt;
            if (ph_nxt != ph_r || ph_r == L_HOLD) begin
                cnt_r <= 13'h0000;
            end else if (cnt_r + 13'h0001 >= per) begin
                cnt_r <= 13'h0000;
                if (ph_r == L_ATK && latt_r < LMAX) latt_r <= latt_r + 7'h01;
                if (ph_r == L_DCY) latt_r <= latt_r - 7'h01;
            end else begin
                cnt_r <= cnt_r + 13'h0001;
            end
        end
    end

    // De-emphasis shelf: low-pass plus scaled remainder
    logic signed [31:0] de_s_r, de_n;
    logic signed [23:0] de_r, de_y;
    // Bypass code would index past the table and poison the state with unknowns
    assign de_n = onep(de_s_r, lim_r, DE_A[(dsel == 2'b00) ? 2'd0 : 2'(dsel - 2'd1)]);
    assign de_y = sat((56'(de_n) + ((((56'(lim_r) <<< 8) - 56'(de_n)) *
                  56'($signed({1'b0, DE_K}))) >>> 16)) >>> 8);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vol_r   <= 24'sh000000;
            eq_r    <= 24'sh000000;
            lim_r   <= 24'sh000000;
            de_r    <= 24'sh000000;
            de_s_r  <= 32'h00000000;
            smp_out <= '0;
        end else if (!conv) begin
            vol_r   <= 24'sh000000;
            eq_r    <= 24'sh000000;
            lim_r   <= 24'sh000000;
            de_r    <= 24'sh000000;
            de_s_r  <= 32'h00000000;
            smp_out <= '0;
        end else begin
            smp_out.vld <= v;
            if (v) begin
                vol_r <= mulg(smp_in.d, gv);
                eq_r  <= path ? ew[5] : vol_r;
                // Boost stays in even with the limiter off
                lim_r <= mulg(eq_r, hdb(UNITY_EFF - 10'({boost, 1'b0}) + 10'(latt_r)));
                de_s_r <= de_n;
                de_r  <= (dsel == 2'b00) ? lim_r : de_y;
                smp_out.d <= pol ? sat(-56'(de_r)) : de_r;
            end
        end
    end

    // Zero run counter watches the incoming words
    logic [10:0] zc_r, zc_nxt;
    logic        am_r;
    always_comb begin
        zc_nxt = zc_r;
        if (v && smp_in.d != 24'sh000000) zc_nxt = 11'h000;
        else if (v && zc_r != ZL) zc_nxt = zc_r + 11'h001;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            zc_r <= 11'h000;
            am_r <= 1'b0;
        end else begin
            zc_r <= zc_nxt;
            am_r <= amen && zc_nxt == ZL;
        end
    end
    assign zero_run_mute = am_r;
    assign stat = {latt_r, sm_r == SM_FULL, am_r};

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_vol_mute;
        v && vol == 8'h00 |=> vol_r == 24'sh000000;
    endproperty
    a_vol_mute: assert property (p_vol_mute) else $error("code zero not muted");
    property p_vol_unity;
        v && vol == 8'hFF && sm_r == 9'h000 |=> vol_r == $past(smp_in.d);
    endproperty
    a_vol_unity: assert property (p_vol_unity) else $error("full code not unity");
    property p_conv_off;
        !conv |=> !smp_out.vld && vol_r == 24'sh000000 && de_r == 24'sh000000;
    endproperty
    a_conv_off: assert property (p_conv_off) else $error("path ran while disabled");
    property p_sm_ramp;
        v && smute && sm_r != SM_FULL |=> sm_r == $past(sm_r) + 9'h001;
    endproperty
    a_sm_ramp: assert property (p_sm_ramp) else $error("soft mute not ramping");
    property p_de_off;
        v && dsel == 2'b00 |=> de_r == $past(lim_r);
    endproperty
    a_de_off: assert property (p_de_off) else $error("de-emphasis not bypassed");
    property p_pol;
        v && !pol |=> smp_out.d == $past(de_r) && smp_out.vld;
    endproperty
    a_pol: assert property (p_pol) else $error("output inverted unasked");
    property p_am_set;
        v && amen && smp_in.d == 24'sh000000 && zc_r == ZL - 11'h001 |=> zero_run_mute;
    endproperty
    a_am_set: assert property (p_am_set) else $error("automute missed");
    property p_am_rel;
        v && smp_in.d != 24'sh000000 |=> !zero_run_mute;
    endproperty
    a_am_rel: assert property (p_am_rel) else $error("automute held");
    property p_am_off;
        !amen |=> !zero_run_mute;
    endproperty
    a_am_off: assert property (p_am_off) else $error("automute while off");
    property p_att_up;
        latt_r > $past(latt_r) |-> $past(27'(mag) > thr_up);
    endproperty
    a_att_up: assert property (p_att_up) else $error("attack below threshold");
    property p_lim_off;
        !lim_en |=> latt_r == 7'h00;
    endproperty
    a_lim_off: assert property (p_lim_off) else $error("limiter active while off");
    property p_eq_byp;
        v && !path |=> eq_r == $past(vol_r);
    endproperty
    a_eq_byp: assert property (p_eq_byp) else $error("equaliser not bypassed");
    c_am: cover property (v && amen ##1 zero_run_mute);
    c_att: cover property (ph_r == L_ATK ##1 latt_r != 7'h00);
    c_dcy: cover property (ph_r == L_DCY && latt_r == 7'h01 ##1 latt_r == 7'h00);
    c_sm: cover property (sm_r == SM_FULL);
endmodule
`default_nettype wire

// File: verif/pbdp_src_model.sv
// Sample source standing in for the host's serial audio feed
`timescale 1ns/1ps
`default_nettype none
module pbdp_src_model
    import pbdp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               go,
    input  wire logic signed [23:0] val,
    input  wire logic        [3:0]  gap,
    output pbdp_smp_t               smp
);
    logic [3:0] cnt_r;
    // Data toggles between strobes so a stale word can never pass as valid
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 4'h0;
            smp   <= '0;
        end else if (go && cnt_r == 4'h0) begin
            cnt_r   <= gap;
            smp.vld <= 1'b1;
            smp.d   <= val;
        end else begin
            cnt_r   <= (cnt_r == 4'h0) ? 4'h0 : cnt_r - 4'h1;
            smp.vld <= 1'b0;
            smp.d   <= ~smp.d;
        end
    end
endmodule
`default_nettype wire

// File: verif/dac_playback_digital_path_tb.sv
// Self-checking bench for the playback digital path
`timescale 1ns/1ps
`default_nettype none
module dac_playback_digital_path_tb import pbdp_pkg::*; ;
    logic               clk, nrst, psel, penable, pwrite, pready, pslverr, er, go;
    logic        [6:0]  paddr;
    logic        [31:0] pwdata, prdata, rd;
    pbdp_smp_t          smp_in, smp_out;
    logic               zero_run_mute, eq_on_record;
    logic        [8:0]  out_power_en;
    logic signed [23:0] val;
    logic        [3:0]  gap;
    int                 bad_count, comparisons;
    localparam logic signed [23:0] V = 24'sh100000;
    localparam logic [4:0] IXS [10] = '{IX_PWR, IX_CTL, IX_VOL, IX_EQ1, IX_EQ2,
        IX_EQ3, IX_EQ4, IX_EQ5, IX_TIM, IX_LVL};
    localparam logic [8:0] RSTS [10] = '{9'h000, 9'h000, 9'h0FF, 9'h12C, 9'h02C,
        9'h02C, 9'h02C, 9'h02C, 9'h032, 9'h000};
    localparam logic [8:0] MSKS [10] = '{MSK_PWR, MSK_CTL, MSK_VOL, MSK_EQ, MSK_EQ,
        MSK_EQ, MSK_EQ, MSK_EQ5, MSK_TIM, MSK_LVL};
    pbdp_top #(.ZRUN_LEN(8)) uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .smp_in(smp_in), .smp_out(smp_out), .zero_run_mute(zero_run_mute),
        .out_power_en(out_power_en), .eq_on_record(eq_on_record));
    pbdp_src_model src (.clk(clk), .nrst(nrst), .go(go), .val(val), .gap(gap), .smp(smp_in));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        $display("FAIL %0t wait ran out", $time);
        end_of_test();
    endtask
    // Request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [6:0] a, input logic [8:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {23'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) hang();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] ix, input logic [8:0] d);
        apb(1'b1, {ix, 2'b00}, d);
    endtask
    task automatic rchk(input logic [4:0] ix, input logic [8:0] e);
        apb(1'b0, {ix, 2'b00}, 9'h000);
        chk(rd, {23'h0, e});
    endtask
    // Counts output words, looking mid-cycle where the registered output is settled
    task automatic run(input int n);
        int k;
        int j;
        k = 0;
        for (j = 0; j < n * 16 && k < n; j++) begin
            @(negedge clk);
            if (smp_out.vld === 1'b1) k++;
        end
        if (k < n) hang();
    endtask
    task automatic near(input logic signed [23:0] lo, input logic signed [23:0] hi);
        chk({31'h0, $signed(smp_out.d) >= lo && $signed(smp_out.d) <= hi}, 32'h1);
    endtask
    task automatic setv(input logic signed [23:0] v);
        @(posedge clk);
        val <= v;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        int i;
        int k;
        {nrst, psel, penable, pwrite, go} = 5'h0;
        paddr = 7'h00;
        pwdata = 32'h0;
        val = V;
        gap = 4'h1;
        bad_count = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 10; i++) rchk(IXS[i], RSTS[i]);
        chk({31'h0, eq_on_record}, 32'h0);
        for (i = 0; i < 10; i++) begin
            wr(IXS[i], 9'h1FF);
            rchk(IXS[i], MSKS[i]);
        end
        chk({23'h0, out_power_en}, {23'h0, MSK_PWR});
        for (i = 0; i < 10; i++) wr(IXS[i], RSTS[i]);
        wr(IX_STAT, 9'h1FF);
        rchk(IX_STAT, 9'h000);
        apb(1'b0, 7'h04, 9'h000);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'b0, 7'h2D, 9'h000);
        chk({31'h0, er}, 32'h1);
        // Converter off: words must be ignored
        go <= 1'b1;
        k = 0;
        repeat (20) begin
            @(negedge clk);
            if (smp_out.vld === 1'b1) k++;
        end
        chk(k, 0);
        wr(IX_PWR, 9'h001);
        run(6);
        chk(smp_out.d, V);
        wr(IX_CTL, 9'h001);
        run(6);
        chk(smp_out.d, -V);
        wr(IX_CTL, 9'h000);
        wr(IX_VOL, 9'h000);
        run(6);
        chk(smp_out.d, 32'h0);
        wr(IX_VOL, 9'h0F3);
        run(6);
        near(24'sh07E000, 24'sh082000);
        wr(IX_VOL, 9'h0FF);
        wr(IX_LVL, 9'h006);
        run(6);
        near(24'sh1F8000, 24'sh208000);
        wr(IX_LVL, 9'h00C);
        run(6);
        near(24'sh3F0000, 24'sh410000);
        wr(IX_LVL, 9'h00F);
        run(6);
        near(24'sh3F0000, 24'sh410000);
        wr(IX_LVL, 9'h000);
        wr(IX_EQ1, 9'h120);
        run(1500);
        near(24'sh3CCCCC, 24'sh433333);
        wr(IX_EQ1, 9'h020);
        @(negedge clk);
        chk({31'h0, eq_on_record}, 32'h1);
        run(20);
        chk(smp_out.d, V);
        wr(IX_EQ1, 9'h12C);
        for (i = 1; i < 4; i++) begin
            wr(IX_CTL, 9'(i << 4));
            run(600);
            near(24'sh0F0000, 24'sh110000);
        end
        wr(IX_CTL, 9'h004);
        setv(24'sh000000);
        run(8);
        chk({31'h0, zero_run_mute}, 32'h0);
        run(2);
        chk({31'h0, zero_run_mute}, 32'h1);
        setv(V);
        run(3);
        chk({31'h0, zero_run_mute}, 32'h0);
        setv(24'sh000000);
        run(12);
        wr(IX_CTL, 9'h000);
        // The mute flop sees the cleared enable one edge after the write lands
        repeat (2) @(negedge clk);
        chk({31'h0, zero_run_mute}, 32'h0);
        setv(V);
        wr(IX_CTL, 9'h040);
        run(20);
        near(24'sh000001, 24'sh0FFFFF);
        run(300);
        chk(smp_out.d, 32'h0);
        rchk(IX_STAT, 9'h002);
        wr(IX_CTL, 9'h000);
        // Ramp up starts from full mute; early steps are still below one LSB
        run(150);
        near(24'sh000001, 24'sh0FFFFF);
        run(300);
        chk(smp_out.d, V);
        setv(24'sh7F0000);
        run(8);
        chk(smp_out.d, 32'h007F0000);
        wr(IX_TIM, 9'h100);
        run(100);
        near(24'sh6A0000, 24'sh78D600);
        apb(1'b0, {IX_STAT, 2'b00}, 9'h000);
        chk({31'h0, rd[8:2] != 7'h0}, 32'h1);
        wr(IX_LVL, 9'h050);
        run(200);
        near(24'sh3E0000, 24'sh440000);
        setv(V);
        run(300);
        chk(smp_out.d, V);
        rchk(IX_STAT, 9'h000);
        end_of_test();
    end
endmodule
`default_nettype wire
